// file: src/rft_cfg.svh
// Purpose: constants of the RF frame transmit control block
// Assumes: 100 MHz clock, 8-bit register port
// Notes: offsets are byte addresses of the register port
// How it works
// - Frame carries length field plus one bits
// - Zero length field sends no frame
// - Block reset clears frame length field
// - Go bit starts sending the data buffer
// - Go clears at completion and block reset
// - Writing go low aborts the transmission
// - Page bit picks lower or upper sixteen bytes
// - Page bit also banks addresses 38h and 39h
// - Of the resets, only the chip reset clears page bit
// - End marker adds two data-one bit times
// - Direct mode drives amplifier from data bit
// - Interframe power-down gates oscillator during gaps
// - Oscillator restarts one ms before end of a gap followed by a frame
// - Initial delay inserted before first frame
// - Done optionally waits one extra gap
// - Frames sent equal repeat count plus one
// - Frames spaced by pseudo-random intervals
// - Block reset clears whole sequence register
// - Block reset from power-on or bit; buffer kept
// - Done flag sticks until acknowledged; irq enabled
// - Zero repeat count: done after one frame
`ifndef RFT_CFG_SVH
`define RFT_CFG_SVH
`define RFT_ADDR_CFG 8'h30
`define RFT_ADDR_LEN 8'h31
`define RFT_ADDR_CTL 8'h32
`define RFT_ADDR_SEQ 8'h33
`define RFT_ADDR_STAT 8'h37
`define RFT_ADDR_BANK0 8'h38
`define RFT_ADDR_BANK1 8'h39
`define RFT_BUF_HI 4'h2
`define RFT_BIT_GO 7
`define RFT_BIT_PAGE 6
`define RFT_BIT_EOM 5
`define RFT_BIT_DATA 7
`define RFT_BIT_INTERFRAME_POWER_DOWN 6
`define RFT_BIT_INITIAL_DELAY_ENABLE 5
`define RFT_BIT_INTERRUPT_AFTER_EXTRA_GAP 4
`define RFT_BIT_FLAG 7
`define RFT_BIT_ACK 4
`define RFT_BIT_IEN 3
`define RFT_BIT_RST 0
`define RFT_ENC_DIRECT 2'h3
`define RFT_RESET_BYTE 8'h00
`define RFT_CLK_NS 10
`define RFT_MS_NS 1000000
`define RFT_BIT_NS 104167
`endif

// file: src/rft_pkg.sv
// Purpose: shared types of the RF frame transmit control block
// Assumes: one-hot state coding
// Notes: constants live in rft_cfg.svh
package rft_pkg;
  typedef logic [7:0] rft_byte_t;
  typedef enum logic [4:0] {
    RFT_IDLE = 5'b0_0001,
    RFT_INIT = 5'b0_0010,
    RFT_FRAME = 5'b0_0100,
    RFT_MARK = 5'b0_1000,
    RFT_GAP = 5'b1_0000
  } rft_state_t;
endpackage

// file: src/rft_ms_tick.sv
// Purpose: millisecond tick for gap timing
// Assumes: restart realigns the tick phase
// Notes: first tick comes a full period after restart
`timescale 1ns/1ns
module rft_ms_tick #(
  parameter int MS_CYCLES = 100000
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Control
  input wire logic restart_i,
  output logic tick_o
);
  logic [19:0] cnt_reg;
  assign tick_o = (cnt_reg == 20'(MS_CYCLES - 1));
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= 20'h0_0000;
    end else if (restart_i || tick_o) begin
      cnt_reg <= 20'h0_0000;
    end else begin
      cnt_reg <= cnt_reg + 20'h0_0001;
    end
  end
endmodule

// file: src/rft_lfsr.sv
// Purpose: 7-bit pseudo-random interval source
// Assumes: seed loaded at transmission start
// Notes: a zero seed stays at zero, so the random part vanishes
`timescale 1ns/1ns
module rft_lfsr (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Control
  input wire logic load_i,
  input wire logic [6:0] seed_i,
  input wire logic step_i,
  output logic [6:0] value_o
);
  logic [6:0] q_reg;
  assign value_o = q_reg;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q_reg <= 7'h00;
    end else if (load_i) begin
      q_reg <= seed_i;
    end else if (step_i) begin
      q_reg <= {q_reg[5:0], q_reg[6] ^ q_reg[5]};
    end
  end
endmodule

// file: src/rft_frame_tx.sv
// Purpose: frame sequencing and register file of the RF transmit control
// Assumes: register strobes synchronous to clock_i, one cycle long
// Notes: data buffer has no reset; block reset leaves it untouched
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ns
`include "rft_cfg.svh"
module rft_frame_tx #(
  parameter int MS_CYCLES = `RFT_MS_NS / `RFT_CLK_NS,
  parameter int BIT_CYCLES = `RFT_BIT_NS / `RFT_CLK_NS
) (
  // Clock and resets
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic rf_power_on_reset_i,
  // Register port
  input wire rft_pkg::rft_byte_t addr_i,
  input wire rft_pkg::rft_byte_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output rft_pkg::rft_byte_t rdata_o,
  // Radio side
  output logic pa_data_o,
  output logic pa_enable_o,
  output logic osc_power_o,
  output logic tx_done_irq_o
);
  import rft_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and decode
  rft_state_t state_reg, state_next;
  rft_byte_t frame_bit_count_reg;
  rft_byte_t seq_reg;
  rft_byte_t base_reg;
  logic [6:0] seed_reg;
  logic [1:0] enc_reg;
  logic go_reg, buffer_page_select_reg, end_marker_enable_reg;
  logic tx_irq_enable_reg, tx_done_flag_reg;
  rft_byte_t rdata_reg;
  logic [7:0] buf_mem [0:31];
  logic [7:0] bit_idx_reg;
  logic [19:0] cyc_reg;
  logic mark_reg;
  logic [3:0] frames_left_reg;
  logic [8:0] gap_ms_reg;
  logic last_gap_reg;
  logic pa_data_reg, pa_enable_reg, osc_power_reg;
  logic ms_tick;
  logic [6:0] lfsr_value;

  wire wr_len = wr_i && (addr_i == `RFT_ADDR_LEN);
  wire wr_ctl = wr_i && (addr_i == `RFT_ADDR_CTL);
  wire wr_seq = wr_i && (addr_i == `RFT_ADDR_SEQ);
  wire wr_stat = wr_i && (addr_i == `RFT_ADDR_STAT);
  wire wr_bank0_lo = wr_i && (addr_i == `RFT_ADDR_BANK0) && !buffer_page_select_reg;
  wire wr_bank1_lo = wr_i && (addr_i == `RFT_ADDR_BANK1) && !buffer_page_select_reg;
  wire wr_bank0_hi = wr_i && (addr_i == `RFT_ADDR_BANK0) && buffer_page_select_reg;
  wire wr_cfg = wr_i && (addr_i == `RFT_ADDR_CFG);
  wire wr_buf = wr_i && (addr_i[7:4] == `RFT_BUF_HI);
  wire flag_ack_bit = wr_stat && wdata_i[`RFT_BIT_ACK];
  wire rf_block_reset = rf_power_on_reset_i || (wr_stat && wdata_i[`RFT_BIT_RST]);

  wire direct_mode = (enc_reg == `RFT_ENC_DIRECT);
  wire interframe_power_down = seq_reg[`RFT_BIT_INTERFRAME_POWER_DOWN];
  wire initial_delay_enable = seq_reg[`RFT_BIT_INITIAL_DELAY_ENABLE];
  wire interrupt_after_extra_gap = seq_reg[`RFT_BIT_INTERRUPT_AFTER_EXTRA_GAP];
  wire [3:0] frame_repeat_count = seq_reg[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing events
  wire in_idle = (state_reg == RFT_IDLE);
  wire in_init = (state_reg == RFT_INIT);
  wire in_frame = (state_reg == RFT_FRAME);
  wire in_mark = (state_reg == RFT_MARK);
  wire in_gap = (state_reg == RFT_GAP);
  wire bit_end = (cyc_reg == 20'(BIT_CYCLES - 1));
  wire last_bit = (bit_idx_reg == frame_bit_count_reg);
  wire start = wr_ctl && wdata_i[`RFT_BIT_GO] && !go_reg && in_idle && !direct_mode;
  wire abort = wr_ctl && !wdata_i[`RFT_BIT_GO] && !in_idle;
  wire start_empty = start && (frame_bit_count_reg == 8'h00);
  wire frame_bits_done = in_frame && bit_end && last_bit;
  wire frame_over = (frame_bits_done && !end_marker_enable_reg) || (in_mark && bit_end && mark_reg);
  wire more_frames = (frames_left_reg != 4'h0);
  // extra gap; not for one frame
  wire extra_gap = interrupt_after_extra_gap && (frame_repeat_count != 4'h0);
  wire gap_over = (in_init || in_gap) && (gap_ms_reg == 9'h000);
  wire enter_gap = frame_over && (more_frames || extra_gap);
  wire enter_init = start && !start_empty && initial_delay_enable;
  wire start_frame = (start && !start_empty && !initial_delay_enable) || (in_init && gap_over)
    || (in_gap && gap_over && !last_gap_reg);
  wire done_evt = start_empty || (frame_over && !more_frames && !extra_gap)
    || (in_gap && gap_over && last_gap_reg);
  wire [8:0] gap_len = {1'b0, base_reg} + {2'b00, (start ? seed_reg : lfsr_value)};
  wire [7:0] cur_byte = buf_mem[bit_idx_reg[7:3]];
  wire cur_bit = cur_byte[3'h7 - bit_idx_reg[2:0]];
  wire osc_gated = in_gap && interframe_power_down && !((gap_ms_reg <= 9'h001) && !last_gap_reg);

  rft_ms_tick #(
    .MS_CYCLES(MS_CYCLES)
  ) u_ms_tick (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .restart_i(enter_gap || enter_init),
    .tick_o(ms_tick)
  );

  rft_lfsr u_lfsr (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .load_i(start),
    .seed_i(seed_reg),
    .step_i(enter_gap),
    .value_o(lfsr_value)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RFT_IDLE: begin
        if (enter_init) begin
          state_next = RFT_INIT;
        end else if (start_frame) begin
          state_next = RFT_FRAME;
        end
      end
      RFT_INIT: begin
        if (gap_over) begin
          state_next = RFT_FRAME;
        end
      end
      RFT_FRAME: begin
        if (frame_bits_done) begin
          state_next = end_marker_enable_reg ? RFT_MARK : (enter_gap ? RFT_GAP : RFT_IDLE);
        end
      end
      RFT_MARK: begin
        if (frame_over) begin
          state_next = enter_gap ? RFT_GAP : RFT_IDLE;
        end
      end
      RFT_GAP: begin
        if (gap_over) begin
          state_next = last_gap_reg ? RFT_IDLE : RFT_FRAME;
        end
      end
      default: begin
        state_next = RFT_IDLE;
      end
    endcase
    if (abort || rf_block_reset) begin
      state_next = RFT_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer flops
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= RFT_IDLE;
      bit_idx_reg <= 8'h00;
      cyc_reg <= 20'h0_0000;
      mark_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bit_idx_reg <= start_frame ? 8'h00 : (in_frame && bit_end) ? bit_idx_reg + 8'h01 : bit_idx_reg;
      cyc_reg <= ((in_frame || in_mark) && !bit_end) ? cyc_reg + 20'h0_0001 : 20'h0_0000;
      mark_reg <= in_mark && (mark_reg ^ bit_end);
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frames_left_reg <= 4'h0;
      gap_ms_reg <= 9'h000;
      last_gap_reg <= 1'b0;
    end else begin
      if (start) begin
        frames_left_reg <= frame_repeat_count;
      end else if (in_gap && gap_over && !last_gap_reg) begin
        frames_left_reg <= frames_left_reg - 4'h1;
      end
      if (enter_gap || enter_init) begin
        gap_ms_reg <= gap_len;
      end else if (ms_tick && (gap_ms_reg != 9'h000)) begin
        gap_ms_reg <= gap_ms_reg - 9'h001;
      end
      if (enter_gap) begin
        last_gap_reg <= !more_frames;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame_bit_count_reg <= `RFT_RESET_BYTE;
      seq_reg <= `RFT_RESET_BYTE;
      go_reg <= 1'b0;
      end_marker_enable_reg <= 1'b0;
    end else if (rf_block_reset) begin
      frame_bit_count_reg <= `RFT_RESET_BYTE;
      seq_reg <= `RFT_RESET_BYTE;
      go_reg <= 1'b0;
      end_marker_enable_reg <= 1'b0;
    end else begin
      if (wr_len) begin
        frame_bit_count_reg <= wdata_i;
      end
      if (wr_seq) begin
        seq_reg <= wdata_i;
      end
      if (done_evt) begin
        go_reg <= 1'b0;
      end else if (wr_ctl) begin
        go_reg <= wdata_i[`RFT_BIT_GO];
      end
      if (wr_ctl) begin
        end_marker_enable_reg <= wdata_i[`RFT_BIT_EOM];
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      buffer_page_select_reg <= 1'b0;
    end else if (wr_ctl) begin
      buffer_page_select_reg <= wdata_i[`RFT_BIT_PAGE];
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      base_reg <= `RFT_RESET_BYTE;
      seed_reg <= 7'h00;
      enc_reg <= 2'h0;
      tx_irq_enable_reg <= 1'b0;
      tx_done_flag_reg <= 1'b0;
    end else if (rf_block_reset) begin
      base_reg <= `RFT_RESET_BYTE;
      seed_reg <= 7'h00;
      enc_reg <= 2'h0;
      tx_irq_enable_reg <= 1'b0;
      tx_done_flag_reg <= 1'b0;
    end else begin
      if (wr_bank0_lo) begin
        base_reg <= wdata_i;
      end
      if (wr_bank1_lo) begin
        seed_reg <= wdata_i[6:0];
      end
      if (wr_bank0_hi || wr_cfg) begin
        enc_reg <= wdata_i[1:0];
      end
      if (wr_stat) begin
        tx_irq_enable_reg <= wdata_i[`RFT_BIT_IEN];
      end
      tx_done_flag_reg <= (tx_done_flag_reg && !flag_ack_bit) || done_evt;
    end
  end

  always_ff @(posedge clock_i) begin
    if (wr_buf) begin
      buf_mem[{buffer_page_select_reg, addr_i[3:0]}] <= wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  wire [7:0] rd_ctl = {go_reg, buffer_page_select_reg, end_marker_enable_reg, 5'h00};
  wire [7:0] rd_stat = {tx_done_flag_reg, 3'h0, tx_irq_enable_reg, 3'h0};
  wire [7:0] rd_bank0 = buffer_page_select_reg ? {6'h00, enc_reg} : base_reg;
  wire [7:0] rd_bank1 = buffer_page_select_reg ? 8'h00 : {1'b0, seed_reg};
  wire [7:0] rd_mux = (addr_i[7:4] == `RFT_BUF_HI) ? buf_mem[{buffer_page_select_reg, addr_i[3:0]}]
    : (addr_i == `RFT_ADDR_LEN) ? frame_bit_count_reg
    : (addr_i == `RFT_ADDR_CTL) ? rd_ctl
    : (addr_i == `RFT_ADDR_SEQ) ? seq_reg
    : (addr_i == `RFT_ADDR_STAT) ? rd_stat
    : (addr_i == `RFT_ADDR_BANK0) ? rd_bank0
    : (addr_i == `RFT_ADDR_BANK1) ? rd_bank1
    : (addr_i == `RFT_ADDR_CFG) ? {6'h00, enc_reg}
    : 8'h00;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rd_i ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Radio outputs
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pa_data_reg <= 1'b0;
      pa_enable_reg <= 1'b0;
      osc_power_reg <= 1'b0;
    end else if (direct_mode) begin
      pa_data_reg <= seq_reg[`RFT_BIT_DATA];
      pa_enable_reg <= go_reg;
      osc_power_reg <= go_reg;
    end else begin
      pa_data_reg <= in_mark || (in_frame && cur_bit);
      pa_enable_reg <= in_frame || in_mark;
      osc_power_reg <= go_reg && !osc_gated;
    end
  end

  assign rdata_o = rdata_reg;
  assign pa_data_o = pa_data_reg;
  assign pa_enable_o = pa_enable_reg;
  assign osc_power_o = osc_power_reg;
  assign tx_done_irq_o = tx_done_flag_reg && tx_irq_enable_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_last_bit;
    in_frame && bit_end && last_bit && !rf_block_reset && !abort;
  endsequence
  sequence s_marker;
    in_mark [*2];
  endsequence

  property p_frame_length;
    in_frame && bit_end && !last_bit && !abort && !rf_block_reset |=> in_frame;
  endproperty
  a_frame_length: assert property (p_frame_length) else $error("frame ended early");
  property p_empty;
    start_empty |=> in_idle && !go_reg && tx_done_flag_reg;
  endproperty
  a_empty: assert property (p_empty) else $error("zero length sent a frame");
  property p_block_reset;
    rf_block_reset |=> frame_bit_count_reg == 8'h00 && seq_reg == 8'h00 && !go_reg;
  endproperty
  a_block_reset: assert property (p_block_reset) else $error("block reset left state");
  property p_done_clears_go;
    done_evt && !rf_block_reset |=> !go_reg && in_idle;
  endproperty
  a_done_clears_go: assert property (p_done_clears_go) else $error("go not cleared");
  property p_abort;
    abort |=> in_idle ##1 !pa_enable_o;
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");
  property p_page_kept;
    rf_block_reset && !wr_ctl |=> $stable(buffer_page_select_reg);
  endproperty
  a_page_kept: assert property (p_page_kept) else $error("page lost on block reset");
  property p_marker;
    s_last_bit ##0 end_marker_enable_reg |=> s_marker ##1 pa_enable_o && pa_data_o;
  endproperty
  a_marker: assert property (p_marker) else $error("end marker missing");
  property p_direct;
    direct_mode && $stable(seq_reg) |=> pa_data_o == $past(seq_reg[`RFT_BIT_DATA]);
  endproperty
  a_direct: assert property (p_direct) else $error("direct data wrong");
  property p_power_kept;
    go_reg && !interframe_power_down && !direct_mode |=> osc_power_o || !$past(go_reg, 1);
  endproperty
  a_power_kept: assert property (p_power_kept) else $error("oscillator dropped");
  property p_flag_set;
    done_evt && !rf_block_reset |=> tx_done_flag_reg [*2] or (tx_done_flag_reg ##1 $past(flag_ack_bit));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("done flag not held");
endmodule

// file: verif/rft_rx_model.sv
// Purpose: over-the-air receiver model facing the amplifier outputs
// Assumes: one carrier bit lasts BIT_CYCLES clocks, first bit present when the amplifier turns on
// Notes: listens only; samples mid-bit and records frame timing against the bench cycle count
`timescale 1ns/1ns
module rft_rx_model #(
  parameter int BIT_CYCLES = 4
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Amplifier side
  input wire logic pa_enable_i,
  input wire logic pa_data_i,
  input wire logic [31:0] cyc_i,
  // Observations
  output int frames_o,
  output int nbits_o,
  output int rise_cyc_o,
  output int fall_cyc_o,
  output int gap_cyc_o,
  output logic [0:271] bits_o
);
  logic en_q = 1'b0;
  int cnt = 0;
  int p;
  int n;
  initial begin
    frames_o = 0;
    nbits_o = 0;
    rise_cyc_o = 0;
    fall_cyc_o = 0;
    gap_cyc_o = 0;
    bits_o = '0;
  end
  //////////////////////////////////////////////////////////////////////////
  // Mid-bit sampling keeps clear of edge jitter between bits
  always @(posedge clock_i) begin
    en_q <= reset_n_i && pa_enable_i;
    p = (pa_enable_i && !en_q) ? 0 : cnt;
    n = (pa_enable_i && !en_q) ? 0 : nbits_o;
    if (pa_enable_i && !en_q) begin
      frames_o <= frames_o + 1;
      rise_cyc_o <= cyc_i;
      gap_cyc_o <= cyc_i - fall_cyc_o;
    end
    if (!pa_enable_i && en_q) begin
      fall_cyc_o <= cyc_i;
    end
    if (pa_enable_i) begin
      cnt <= p + 1;
      if (p % BIT_CYCLES == BIT_CYCLES / 2 && n < 272) begin
        bits_o[n] <= pa_data_i;
        n = n + 1;
      end
      nbits_o <= n;
    end
  end
endmodule

// file: verif/rft_frame_tx_tb_top.sv
// Purpose: self-checking bench of the RF frame transmit control
// Assumes: shortened timing, 20 clocks a millisecond and 4 clocks a bit
// Notes: done is awaited on the interrupt output, so the interrupt enable stays set
`timescale 1ns/1ns
`include "rft_cfg.svh"
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
  $display("unexpected %s: expected %0h seen %0h", what, exp, got); end end
module rft_frame_tx_tb_top;
  import rft_pkg::*;
  localparam int MS = 20;
  localparam int BITC = 4;
  localparam int LIMIT = 60000;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic rf_power_on_reset_i = 1'b0;
  rft_byte_t addr_i = 8'h00;
  rft_byte_t wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  rft_byte_t rdata_o;
  logic pa_data_o;
  logic pa_enable_o;
  logic osc_power_o;
  logic tx_done_irq_o;
  int cyc = 0;
  int n_fail = 0;
  int tests_run = 0;
  int frames, nbits, rise_cyc, fall_cyc, gap_cyc, f0, go_cyc, done_cyc;
  int osc_off = 0;
  logic gap_watch = 1'b0;
  logic [0:271] bits;
  rft_byte_t shadow [0:31];
  rft_byte_t v;
  //////////////////////////////////////////////////////////////////////////
  rft_frame_tx #(.MS_CYCLES(MS), .BIT_CYCLES(BITC)) u_dut (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .rf_power_on_reset_i(rf_power_on_reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pa_data_o(pa_data_o), .pa_enable_o(pa_enable_o), .osc_power_o(osc_power_o),
    .tx_done_irq_o(tx_done_irq_o));
  rft_rx_model #(.BIT_CYCLES(BITC)) u_rx (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .pa_enable_i(pa_enable_o), .pa_data_i(pa_data_o),
    .cyc_i(cyc), .frames_o(frames), .nbits_o(nbits), .rise_cyc_o(rise_cyc), .fall_cyc_o(fall_cyc),
    .gap_cyc_o(gap_cyc), .bits_o(bits));
  always #5 clock_i = ~clock_i;
  // Oscillator-off count only between first frame start and done
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (gap_watch && frames > f0 && tx_done_irq_o === 1'b0 && osc_power_o === 1'b0) begin
      osc_off <= osc_off + 1;
    end
    if (cyc == LIMIT) begin
      n_fail++;
      end_of_test();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr(input rft_byte_t a, input rft_byte_t d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input rft_byte_t a, output rft_byte_t d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    d = rdata_o;
  endtask
  task automatic chk_reg(input string what, input rft_byte_t a, input rft_byte_t exp);
    rd(a, v);
    `CHK(what, exp, v)
  endtask
  task automatic send(input rft_byte_t len, input rft_byte_t ctl, input rft_byte_t seq);
    wr(`RFT_ADDR_LEN, len);
    wr(`RFT_ADDR_SEQ, seq);
    f0 = frames;
    wr(`RFT_ADDR_CTL, 8'h80 | ctl);
    go_cyc = cyc;
  endtask
  task automatic wait_done(input int limit);
    int k;
    k = 0;
    while (tx_done_irq_o !== 1'b1 && k < limit) begin
      @(posedge clock_i);
      k++;
    end
    done_cyc = cyc;
    // Let the receiver log the amplifier fall
    repeat (2) @(negedge clock_i);
    `CHK("done irq", 1'b1, tx_done_irq_o)
  endtask
  task automatic ack;
    wr(`RFT_ADDR_STAT, 8'h18);
    @(negedge clock_i);
    `CHK("irq after ack", 1'b0, tx_done_irq_o)
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    chk_reg("length", `RFT_ADDR_LEN, 8'h00);
    chk_reg("ctrl", `RFT_ADDR_CTL, 8'h00);
    chk_reg("sequence", `RFT_ADDR_SEQ, 8'h00);
    chk_reg("unmapped", 8'h3F, 8'h00);
    for (int i = 0; i < 32; i++) begin
      shadow[i] = rft_byte_t'(i * 37 + 90);
      if (i == 16) wr(`RFT_ADDR_CTL, 8'h40);
      wr(rft_byte_t'(8'h20 + i % 16), shadow[i]);
    end
    chk_reg("upper page byte", 8'h20, shadow[16]);
    wr(`RFT_ADDR_BANK0, 8'h03);
    chk_reg("encoding alias", `RFT_ADDR_CFG, 8'h03);
    chk_reg("upper bank seed slot", `RFT_ADDR_BANK1, 8'h00);
    wr(`RFT_ADDR_LEN, 8'h55);
    wr(`RFT_ADDR_SEQ, 8'h3F);
    wr(`RFT_ADDR_STAT, 8'h01);
    chk_reg("length after block reset", `RFT_ADDR_LEN, 8'h00);
    chk_reg("sequence after block reset", `RFT_ADDR_SEQ, 8'h00);
    chk_reg("page kept", `RFT_ADDR_CTL, 8'h40);
    chk_reg("buffer kept", 8'h20, shadow[16]);
    wr(`RFT_ADDR_CTL, 8'h00);
    chk_reg("lower page byte", 8'h20, shadow[0]);
    wr(`RFT_ADDR_LEN, 8'h07);
    @(posedge clock_i);
    rf_power_on_reset_i <= 1'b1;
    @(posedge clock_i);
    rf_power_on_reset_i <= 1'b0;
    chk_reg("length after power-on reset", `RFT_ADDR_LEN, 8'h00);
    wr(`RFT_ADDR_STAT, 8'h08);
  endtask
  task automatic t_frames;
    int lens [3] = '{1, 11, 255};
    logic ok;
    send(8'h00, 8'h00, 8'h00);
    wait_done(10);
    `CHK("zero length frames", 0, frames - f0)
    ack();
    foreach (lens[j]) begin
      send(rft_byte_t'(lens[j]), 8'h00, 8'h00);
      wait_done(1200);
      `CHK("frame count", 1, frames - f0)
      `CHK("bit count", lens[j] + 1, nbits)
      ok = 1'b1;
      for (int i = 0; i <= lens[j]; i++) ok &= (bits[i] === shadow[i / 8][7 - i % 8]);
      `CHK("frame bits", 1'b1, ok)
      chk_reg("go cleared", `RFT_ADDR_CTL, 8'h00);
      chk_reg("done flag", `RFT_ADDR_STAT, 8'h88);
      ack();
    end
    send(8'h07, 8'h20, 8'h00);
    wait_done(200);
    `CHK("marker bit count", 10, nbits)
    `CHK("marker level", 2'b11, bits[8:9])
    ack();
  endtask
  task automatic t_timing;
    wr(`RFT_ADDR_BANK0, 8'h01);
    wr(`RFT_ADDR_BANK1, 8'h05);
    for (int f = 0; f < 2; f++) begin
      send(8'h03, 8'h00, rft_byte_t'(f * 16 + 2));
      wait_done(2000);
      `CHK("repeat frames", 3, frames - f0)
      // Seed 5 stepped once: second gap is 1 + 10 ms
      `CHK("gap spaced", 1'b1, gap_cyc >= 11 * MS && gap_cyc <= 11 * MS + 3)
      `CHK("done delay", 1'b1, f ? (done_cyc - fall_cyc >= MS) : (done_cyc - fall_cyc <= 3))
      ack();
    end
    wr(`RFT_ADDR_BANK1, 8'h00);
    wr(`RFT_ADDR_BANK0, 8'h02);
    for (int s = 0; s < 2; s++) begin
      send(8'h03, 8'h00, rft_byte_t'(s * 32));
      wait_done(1000);
      `CHK("first frame delay", 1'b1, s ? (rise_cyc - go_cyc >= 2 * MS) : (rise_cyc - go_cyc <= 3))
      ack();
    end
    wr(`RFT_ADDR_BANK0, 8'h03);
    for (int d = 0; d < 2; d++) begin
      osc_off = 0;
      send(8'h03, 8'h00, rft_byte_t'(d * 64 + 1));
      gap_watch = 1'b1;
      wait_done(1000);
      gap_watch = 1'b0;
      `CHK("osc kept", 1'b1, d ? 1'b1 : osc_off == 0)
      `CHK("osc restart", 1'b1, d ? (osc_off >= MS && osc_off <= 2 * MS + 2) : 1'b1)
      ack();
    end
  endtask
  task automatic t_abort_direct;
    send(8'hFF, 8'h00, 8'h00);
    repeat (50) @(posedge clock_i);
    wr(`RFT_ADDR_CTL, 8'h00);
    repeat (3) @(posedge clock_i);
    `CHK("amp off after abort", 1'b0, pa_enable_o)
    `CHK("cut short", 1'b1, nbits < 256)
    chk_reg("no done flag", `RFT_ADDR_STAT, 8'h08);
    wr(`RFT_ADDR_CFG, 8'h03);
    wr(`RFT_ADDR_SEQ, 8'h80);
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    `CHK("direct high", 1'b1, pa_data_o)
    wr(`RFT_ADDR_SEQ, 8'h00);
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    `CHK("direct low", 1'b0, pa_data_o)
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clock_i);
    reset_n_i <= 1'b1;
    t_regs();
    t_frames();
    t_timing();
    t_abort_direct();
    end_of_test();
  end
endmodule
